// file: inc/ilc_pkg.sv
// Package for the in-band loop code and error count control block
package ilc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_PATTERN = 8'h0D;
  localparam logic [7:0] OFS_LENGTH = 8'h0F;
  localparam logic [7:0] OFS_TX_CODE = 8'h10;
  localparam logic [7:0] OFS_ACT_CODE = 8'h11;
  localparam logic [7:0] OFS_DEACT_CODE = 8'h12;
  localparam logic [7:0] OFS_CTL = 8'h13;
  localparam logic [7:0] OFS_CNT_LOW = 8'h18;
  localparam logic [7:0] OFS_CNT_HIGH = 8'h19;
  // Field positions
  localparam int CTL_VIOL = 6;
  localparam int CTL_PERR = 5;
  localparam int CTL_EXZ = 4;
  localparam int CTL_TYPE = 2;
  localparam int CTL_MODE = 1;
  localparam int CTL_TRF = 0;
  localparam int LEN_TX = 4;
  localparam int LEN_ACT = 2;
  localparam int LEN_DEACT = 0;
  localparam int TRANSMIT_PATTERN_SELECT_POS = 5;
  localparam logic [7:0] CTL_WMASK = 8'h7F;
  localparam logic [7:0] LEN_WMASK = 8'h3F;
  // Values after reset
  localparam logic [7:0] TX_CODE_RST = 8'h01;
  localparam logic [7:0] ACT_CODE_RST = 8'h01;
  localparam logic [7:0] DEACT_CODE_RST = 8'h09;
  localparam logic [7:0] LEN_RST = 8'h01;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [2:0] CODE_MIN_TOP = 3'h4;
  // Timing: one-second report period at a 50 ns clock
  localparam int SECOND_NS = 1_000_000_000;
  localparam int CLK_NS = 50;
  localparam int SECOND_CYCLES = SECOND_NS / CLK_NS;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 1;

  typedef enum logic [1:0] {
    TRANSMIT_PATTERN_SELECT_NORMAL = 2'b00, TRANSMIT_PATTERN_SELECT_ONES = 2'b01, TRANSMIT_PATTERN_SELECT_PRBS = 2'b10, TRANSMIT_PATTERN_SELECT_CODE = 2'b11
  } ilc_transmit_pattern_select_e;
  typedef enum logic [1:0] {
    ERR_PATTERN = 2'b00, ERR_EXZ = 2'b01, ERR_VIOL = 2'b10, ERR_BOTH = 2'b11
  } ilc_err_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ilc_bus_s;
  typedef struct packed {
    logic pattern;
    logic exz_ansi;
    logic exz_fcc;
    logic violation;
  } ilc_rx_err_s;
  typedef struct packed {
    logic [7:0] act_code;
    logic [1:0] act_len;
    logic [7:0] deact_code;
    logic [1:0] deact_len;
    logic exz_fcc;
  } ilc_codes_s;
  typedef struct packed {
    logic [7:0] tx_code;
    logic [7:0] act_code;
    logic [7:0] deact_code;
    logic [7:0] lens;
    logic [7:0] ctl;
    logic [1:0] transmit_pattern_select;
    logic [15:0] count;
    logic [15:0] result;
    logic [14:0] prbs;
    logic [2:0] code_idx;
    logic bpv_arm;
    logic err_arm;
    logic tx_data;
    logic tx_valid;
    logic tx_bpv;
    logic [7:0] rdata;
    logic [24:0] sec_cnt;
  } ilc_state_s;
  localparam ilc_state_s STATE_RST = '{tx_code: TX_CODE_RST, act_code: ACT_CODE_RST,
    deact_code: DEACT_CODE_RST, lens: LEN_RST, prbs: PRBS_SEED, code_idx: CODE_MIN_TOP,
    default: '0};
endpackage : ilc_pkg

// file: rtl/ilc_top.sv
// Loop code registers, error insertion, error counter and transmit FIFO
`timescale 1ns/1ps
// Notes on behaviour
// - Transmit loop code is 8 bits, resets to 00000001.
// - Repeating code uses the low bits chosen by the length, 5 to 8.
// - Receive activate code is 8 bits, resets to 00001.
// - Receive deactivate code is 8 bits, resets to 001001.
// - Rising violation insert bit injects exactly one bipolar violation.
// - Rising pattern error insert bit inverts exactly one PRBS bit.
// - Excess-zero select 0 uses ANSI, 1 uses FCC definition.
// - Error type picks pattern, excess-zero, violation, or violation plus excess-zero.
// - Counter mode 0 is manual report, 1 is automatic report.
// - Rising transfer bit copies count to results and restarts the counter from that cycle's errors.
// - Control register resets to zero; its top bit is reserved.
// - Transmit length field 00..11 gives 5..8 bits, default 5.
// - Receive lengths use same coding; activate defaults 5, deactivate 6.
// - Pattern select 11 sends the transmit loop code repeatedly.

// Small FIFO between the system side and the transmit line
module ilc_fifo
  import ilc_pkg::*;
#(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fill;
    logic full;
    logic empty;
  } ilc_fifo_s;
  ilc_fifo_s st_reg;
  ilc_fifo_s st_next;
  logic push;
  logic pop;
  logic [AW:0] fill_n;

  // Full and empty are registered so ready never depends on the far side
  always_comb begin
    st_next = st_reg;
    push = in_valid && !st_reg.full;
    pop = out_ready && !st_reg.empty;
    fill_n = st_reg.fill + (AW+1)'(push) - (AW+1)'(pop);
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    st_next.fill = fill_n;
    st_next.full = (fill_n == (AW+1)'(DEPTH));
    st_next.empty = (fill_n == '0);
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '{empty: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready = !st_reg.full;
  assign out_valid = !st_reg.empty;
  assign out_data = st_reg.mem[st_reg.rp];
endmodule : ilc_fifo

// Register bank and line-side maintenance logic
module ilc_top
  import ilc_pkg::*;
#(
  parameter int SECOND_LEN = SECOND_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire ilc_bus_s bus,
  output logic [DATA_W-1:0] rdata,
  // System transmit data
  input wire logic sys_valid,
  output logic sys_ready,
  input wire logic sys_data,
  // Transmit line, one bit per line_tick
  input wire logic line_tick,
  output logic line_tx_valid,
  output logic line_tx_data,
  output logic line_tx_bpv,
  // Receive errors and code settings for the detector
  input wire ilc_rx_err_s rx_err,
  output ilc_codes_s codes
);
  ilc_state_s st_reg;
  ilc_state_s st_next;
  logic fifo_valid;
  logic fifo_data;
  logic fifo_take;
  logic viol_rise;
  logic perr_rise;
  logic trf_rise;
  logic expiry;
  logic transfer;
  logic exz_evt;
  logic [1:0] inc;
  logic [16:0] sum;

  // Top index of the repeating code for a length field
  function automatic logic [2:0] code_top(input logic [1:0] len);
    code_top = CODE_MIN_TOP + {1'b0, len};
  endfunction : code_top

  ilc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(sys_valid),
    .in_ready(sys_ready),
    .in_data(sys_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  // FIFO drains only while normal data is sent; other patterns stall it
  assign fifo_take = line_tick && (ilc_transmit_pattern_select_e'(st_reg.transmit_pattern_select) == TRANSMIT_PATTERN_SELECT_NORMAL);

  always_comb begin
    st_next = st_reg;
    viol_rise = 1'b0;
    perr_rise = 1'b0;
    trf_rise = 1'b0;
    // Register writes; insert and transfer act on a 0 to 1 change only
    if (bus.wr) begin
      case (bus.addr)
        OFS_PATTERN: st_next.transmit_pattern_select = bus.wdata[TRANSMIT_PATTERN_SELECT_POS+:2];
        OFS_LENGTH: st_next.lens = bus.wdata & LEN_WMASK;
        OFS_TX_CODE: st_next.tx_code = bus.wdata;
        OFS_ACT_CODE: st_next.act_code = bus.wdata;
        OFS_DEACT_CODE: st_next.deact_code = bus.wdata;
        OFS_CTL: begin
          st_next.ctl = bus.wdata & CTL_WMASK;
          viol_rise = bus.wdata[CTL_VIOL] && !st_reg.ctl[CTL_VIOL];
          perr_rise = bus.wdata[CTL_PERR] && !st_reg.ctl[CTL_PERR];
          trf_rise = bus.wdata[CTL_TRF] && !st_reg.ctl[CTL_TRF];
        end
        default: ;
      endcase
    end
    // Transmit bit selection, one bit per line tick
    st_next.tx_valid = line_tick;
    st_next.tx_bpv = 1'b0;
    if (line_tick) begin
      st_next.tx_bpv = st_reg.bpv_arm;
      st_next.bpv_arm = 1'b0;
      case (ilc_transmit_pattern_select_e'(st_reg.transmit_pattern_select))
        // Underrun sends zero rather than stalling the line
        TRANSMIT_PATTERN_SELECT_NORMAL: st_next.tx_data = fifo_valid && fifo_data;
        TRANSMIT_PATTERN_SELECT_ONES: st_next.tx_data = 1'b1;
        TRANSMIT_PATTERN_SELECT_PRBS: begin
          st_next.tx_data = st_reg.prbs[14] ^ st_reg.err_arm;
          st_next.err_arm = 1'b0;
          st_next.prbs = {st_reg.prbs[13:0], st_reg.prbs[14] ^ st_reg.prbs[13]};
        end
        TRANSMIT_PATTERN_SELECT_CODE: begin
          st_next.tx_data = st_reg.tx_code[st_reg.code_idx];
          st_next.code_idx = (st_reg.code_idx == 3'h0) ?
            code_top(st_reg.lens[LEN_TX+:2]) : st_reg.code_idx - 3'h1;
        end
        default: st_next.tx_data = 1'b0;
      endcase
    end
    // Outside code mode the index waits at the first bit of the code
    if (ilc_transmit_pattern_select_e'(st_reg.transmit_pattern_select) != TRANSMIT_PATTERN_SELECT_CODE) begin
      st_next.code_idx = code_top(st_reg.lens[LEN_TX+:2]);
    end
    // Arming after the tick lets a new request win over the consume
    if (viol_rise) begin
      st_next.bpv_arm = 1'b1;
    end
    if (perr_rise) begin
      st_next.err_arm = 1'b1;
    end
    exz_evt = st_reg.ctl[CTL_EXZ] ? rx_err.exz_fcc : rx_err.exz_ansi;
    case (ilc_err_e'(st_reg.ctl[CTL_TYPE+:2]))
      ERR_PATTERN: inc = {1'b0, rx_err.pattern};
      ERR_EXZ: inc = {1'b0, exz_evt};
      ERR_VIOL: inc = {1'b0, rx_err.violation};
      ERR_BOTH: inc = {1'b0, rx_err.violation} + {1'b0, exz_evt};
      default: inc = 2'b00;
    endcase
    // One-second timer runs always; only automatic mode uses it
    expiry = (st_reg.sec_cnt == 25'(SECOND_LEN - 1));
    st_next.sec_cnt = expiry ? '0 : st_reg.sec_cnt + 25'h000_0001;
    transfer = trf_rise || (st_reg.ctl[CTL_MODE] && expiry);
    sum = {1'b0, st_reg.count} + {15'h0000, inc};
    if (transfer) begin
      st_next.result = st_reg.count;
      st_next.count = {14'h0000, inc};
    end else begin
      st_next.count = sum[16] ? CNT_MAX : sum[15:0];
    end
    // Read data stands only in the cycle after the strobe
    st_next.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        OFS_PATTERN: st_next.rdata = {1'b0, st_reg.transmit_pattern_select, 5'h00};
        OFS_LENGTH: st_next.rdata = st_reg.lens;
        OFS_TX_CODE: st_next.rdata = st_reg.tx_code;
        OFS_ACT_CODE: st_next.rdata = st_reg.act_code;
        OFS_DEACT_CODE: st_next.rdata = st_reg.deact_code;
        OFS_CTL: st_next.rdata = st_reg.ctl;
        OFS_CNT_LOW: st_next.rdata = st_reg.result[7:0];
        OFS_CNT_HIGH: st_next.rdata = st_reg.result[15:8];
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state flops
  assign rdata = st_reg.rdata;
  assign line_tx_valid = st_reg.tx_valid;
  assign line_tx_data = st_reg.tx_data;
  assign line_tx_bpv = st_reg.tx_bpv;
  assign codes = '{act_code: st_reg.act_code, act_len: st_reg.lens[LEN_ACT+:2],
    deact_code: st_reg.deact_code, deact_len: st_reg.lens[LEN_DEACT+:2],
    exz_fcc: st_reg.ctl[CTL_EXZ]};

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence ctl_write_bit(int pos);
    bus.wr && bus.addr == OFS_CTL && bus.wdata[pos];
  endsequence

  chk_reset_codes: assert property ($rose(rst_n) |->
    st_reg.tx_code == 8'h01 && st_reg.act_code == 8'h01 && st_reg.deact_code == 8'h09)
    else $error("loop codes wrong after reset");
  chk_ctl_reset: assert property ($rose(rst_n) |-> st_reg.ctl == 8'h00
    && st_reg.lens == 8'h01) else $error("control fields wrong after reset");
  // A line tick taken while the given pattern is selected
  sequence tick_in(logic [1:0] p);
    line_tick && st_reg.transmit_pattern_select == p;
  endsequence

  chk_viol_arm: assert property (ctl_write_bit(CTL_VIOL)
    ##0 !st_reg.ctl[CTL_VIOL] |=> st_reg.bpv_arm) else $error("violation not armed");
  chk_viol_single: assert property (st_reg.bpv_arm && line_tick && !viol_rise
    |=> line_tx_bpv && !st_reg.bpv_arm)
    else $error("violation not sent once");
  // Without an armed request no bit may carry a violation
  chk_viol_none: assert property (!st_reg.bpv_arm |=> !line_tx_bpv)
    else $error("violation sent without request");
  // The error is consumed by the bit that carries it, unless rearmed at once
  chk_perr_once: assert property (tick_in(TRANSMIT_PATTERN_SELECT_PRBS) ##0 st_reg.err_arm
    ##0 !perr_rise |=> !st_reg.err_arm) else $error("pattern error not consumed");
  chk_perr_clean: assert property (tick_in(TRANSMIT_PATTERN_SELECT_PRBS) ##0 !st_reg.err_arm
    |=> line_tx_data == $past(st_reg.prbs[14])) else $error("pattern bit corrupted");
  // FCC definition picks the other excess-zero input
  chk_exz_fcc: assert property (st_reg.ctl[3:2] == 2'b01 && st_reg.ctl[CTL_EXZ]
    && rx_err.exz_fcc && !transfer && st_reg.count < 16'hFFFF
    |=> st_reg.count == $past(st_reg.count) + 16'h0001) else $error("fcc zero not counted");
  // Both kinds in one cycle add two to the count
  chk_both_count: assert property (st_reg.ctl[4:2] == 3'b011 && rx_err.violation
    && rx_err.exz_ansi && !transfer && st_reg.count < 16'hFFFE
    |=> st_reg.count == $past(st_reg.count) + 16'h0002) else $error("double error miscounted");
  // Saturation keeps a full counter from wrapping to a small value
  chk_count_sat: assert property (st_reg.count == 16'hFFFF && !transfer
    |=> st_reg.count == 16'hFFFF) else $error("counter wrapped");
  // Manual mode keeps the result until software asks again
  chk_manual_hold: assert property (!st_reg.ctl[CTL_MODE] && !trf_rise
    |=> st_reg.result == $past(st_reg.result)) else $error("result changed in manual mode");
  // A transfer bit already set gives no second transfer
  chk_trf_fresh: assert property (ctl_write_bit(CTL_TRF) ##0 st_reg.ctl[CTL_TRF]
    ##0 !st_reg.ctl[CTL_MODE] |=> st_reg.result == $past(st_reg.result))
    else $error("transfer without fresh edge");
  // Reserved top bit never holds a one
  chk_ctl_reserved: assert property (ctl_write_bit(7) |=> !st_reg.ctl[7])
    else $error("reserved control bit stored");
  chk_perr_invert: assert property (st_reg.err_arm && line_tick
    && st_reg.transmit_pattern_select == TRANSMIT_PATTERN_SELECT_PRBS |=> line_tx_data != $past(st_reg.prbs[14]))
    else $error("pattern error not inserted");
  chk_code_bit: assert property (line_tick && st_reg.transmit_pattern_select == TRANSMIT_PATTERN_SELECT_CODE
    |=> line_tx_data == $past(st_reg.tx_code[st_reg.code_idx]))
    else $error("loop code bit wrong");
  chk_code_wrap: assert property (line_tick && st_reg.transmit_pattern_select == TRANSMIT_PATTERN_SELECT_CODE
    && st_reg.code_idx == 3'h0 && !bus.wr |=> st_reg.code_idx == 3'h4
    + {1'b0, st_reg.lens[LEN_TX+:2]}) else $error("code length wrap wrong");
  chk_exz_ansi: assert property (st_reg.ctl[3:2] == 2'b01 && !st_reg.ctl[CTL_EXZ]
    && rx_err.exz_ansi && !transfer && st_reg.count < 16'hFFFF
    |=> st_reg.count == $past(st_reg.count) + 16'h0001) else $error("ansi zero not counted");
  chk_pattern_only: assert property (st_reg.ctl[3:2] == 2'b00 && !rx_err.pattern
    && !transfer |=> st_reg.count == $past(st_reg.count)) else $error("wrong error counted");
  chk_manual_trf: assert property (trf_rise |=> st_reg.result == $past(st_reg.count)
    && st_reg.count <= 16'h0002) else $error("manual transfer failed");
  chk_auto_trf: assert property (st_reg.ctl[CTL_MODE] && expiry
    |=> st_reg.result == $past(st_reg.count)) else $error("auto transfer missing");
endmodule : ilc_top

// file: sim/ilc_line_model.sv
// Far-end line equipment model: pulls bits from the block and reports receive errors
`timescale 1ns/1ps
module ilc_line_model
  import ilc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic tick_en,
  input wire ilc_rx_err_s err_req,
  // Line
  output logic line_tick,
  input wire logic line_tx_valid,
  input wire logic line_tx_data,
  input wire logic line_tx_bpv,
  output ilc_rx_err_s rx_err,
  // Observed traffic
  output logic [63:0] bits_reg,
  output logic [7:0] bpv_reg
);
  // Ticks may run back to back; received bits are kept newest at bit 0
  always_ff @(posedge clk) begin
    line_tick <= rst_n && tick_en;
    rx_err <= rst_n ? err_req : '0;
    if (!rst_n) begin
      bits_reg <= '0;
      bpv_reg <= '0;
    end else if (line_tx_valid) begin
      bits_reg <= {bits_reg[62:0], line_tx_data};
      bpv_reg <= bpv_reg + 8'(line_tx_bpv);
    end
  end
endmodule : ilc_line_model

// file: sim/ilc_top_tb.sv
// Self-checking bench for the loop code and error count block
`timescale 1ns/1ps
module ilc_top_tb
  import ilc_pkg::*;
;
  localparam int SEC = 50;
  localparam logic [7:0] RA [7] = '{OFS_TX_CODE, OFS_ACT_CODE, OFS_DEACT_CODE, OFS_CTL,
    OFS_LENGTH, OFS_PATTERN, 8'h1F};
  localparam logic [7:0] RV [7] = '{8'h01, 8'h01, 8'h09, 8'h00, 8'h01, 8'h00, 8'h00};
  logic clk;
  logic rst_n;
  ilc_bus_s bus;
  logic [7:0] rdata;
  logic sys_valid;
  logic sys_ready;
  logic sys_data;
  logic line_tick;
  logic line_tx_valid;
  logic line_tx_data;
  logic line_tx_bpv;
  ilc_rx_err_s rx_err;
  ilc_rx_err_s err_req;
  ilc_codes_s codes;
  logic tick_en;
  logic [63:0] bits_reg;
  logic [7:0] bpv_reg;
  int err_total;
  int n_tests;

  // Design and far end
  ilc_top #(.SECOND_LEN(SEC)) u_ilc_top (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .sys_valid(sys_valid), .sys_ready(sys_ready), .sys_data(sys_data),
    .line_tick(line_tick), .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data),
    .line_tx_bpv(line_tx_bpv), .rx_err(rx_err), .codes(codes));
  ilc_line_model u_ilc_line_model (.clk(clk), .rst_n(rst_n), .tick_en(tick_en),
    .err_req(err_req), .line_tick(line_tick), .line_tx_valid(line_tx_valid),
    .line_tx_data(line_tx_data), .line_tx_bpv(line_tx_bpv), .rx_err(rx_err),
    .bits_reg(bits_reg), .bpv_reg(bpv_reg));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Bus tasks leave an idle cycle so no signal is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    // Read data stand for this one cycle; look while they are settled
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), 16'(d), 16'(e));
  endtask : rd_chk

  task automatic cnt_chk(input logic [15:0] e);
    logic [7:0] l;
    logic [7:0] h;
    rd(OFS_CNT_LOW, l);
    rd(OFS_CNT_HIGH, h);
    chk("count", {h, l}, e);
  endtask : cnt_chk

  // Extra cycles let the last bits pass the output register
  task automatic ticks(input int n);
    tick_en <= 1'b1;
    repeat (n) @(posedge clk);
    tick_en <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ticks

  task automatic ev(input logic [3:0] e);
    err_req <= ilc_rx_err_s'(e);
    @(posedge clk);
    err_req <= '0;
    @(posedge clk);
  endtask : ev

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // Watchdog, far beyond the roughly 1100 cycles the tests take
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  // Main sequence
  initial begin
    logic [7:0] m;
    logic [7:0] c;
    logic [7:0] b;
    int x;
    int e;
    int pushed;
    logic [15:0] fexp;
    logic [63:0] pr [2];
    rst_n = 1'b0;
    bus = '0;
    sys_valid = 1'b0;
    sys_data = 1'b0;
    tick_en = 1'b0;
    err_req = '0;
    err_total = 0;
    n_tests = 0;
    pushed = 0;
    fexp = '0;
    do_reset();
    chk("codes", {codes.act_code, codes.deact_code}, 16'h0109);
    chk("lens", 16'({codes.act_len, codes.deact_len, codes.exz_fcc}), 16'h0002);
    for (int i = 0; i < 7; i++) rd_chk(RA[i], RV[i]);
    wr(OFS_CTL, 8'hFF);
    rd_chk(OFS_CTL, 8'h7F);
    chk("fcc", 16'(codes.exz_fcc), 16'h0001);
    wr(8'h1F, 8'hFF);
    rd_chk(8'h1F, 8'h00);
    wr(OFS_ACT_CODE, 8'hA5);
    wr(OFS_DEACT_CODE, 8'h3C);
    wr(OFS_LENGTH, 8'hFF);
    wr(OFS_CTL, 8'h00);
    rd_chk(OFS_LENGTH, 8'h3F);
    chk("codes", {codes.act_code, codes.deact_code}, 16'hA53C);
    chk("lens", 16'({codes.act_len, codes.deact_len}), 16'h000F);
    // Fill the buffer with the line stalled, then drain past empty
    sys_valid <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      sys_data <= i[0] ^ i[2];
      // Ready is judged mid-cycle, before the edge that takes the bit
      @(negedge clk);
      if (sys_ready === 1'b1) begin
        pushed++;
        fexp = {fexp[14:0], sys_data};
      end
      @(posedge clk);
    end
    sys_valid <= 1'b0;
    chk("pushed", 16'(pushed), 16'(FIFO_DEPTH));
    chk("full", 16'(sys_ready), 16'h0000);
    ticks(18);
    chk("drain", bits_reg[17:2], fexp);
    chk("empty", 16'(bits_reg[1:0]), 16'h0000);
    chk("ready", 16'(sys_ready), 16'h0001);
    // Loop code: period and weight follow the length field
    wr(OFS_TX_CODE, 8'h96);
    wr(OFS_PATTERN, 8'h60);
    for (int l = 0; l < 4; l++) begin
      wr(OFS_LENGTH, 8'(l << LEN_TX));
      ticks(40);
      m = 8'((1 << (l + 5)) - 1);
      chk("period", bits_reg[15:0], bits_reg[l + 20 -: 16]);
      chk("ones", 16'($countones(bits_reg[7:0] & m)), 16'($countones(8'h96 & m)));
    end
    // One violation per rising insert bit, none for a held bit
    wr(OFS_PATTERN, 8'h00);
    b = bpv_reg;
    wr(OFS_CTL, 8'h40);
    ticks(4);
    wr(OFS_CTL, 8'h40);
    ticks(4);
    chk("bpv", 16'(bpv_reg - b), 16'h0001);
    wr(OFS_CTL, 8'h00);
    wr(OFS_CTL, 8'h40);
    ticks(4);
    chk("bpv", 16'(bpv_reg - b), 16'h0002);
    // Two identical runs of the pattern, one with an error armed
    for (int r = 0; r < 2; r++) begin
      do_reset();
      wr(OFS_PATTERN, 8'h40);
      wr(OFS_CTL, r == 1 ? 8'h20 : 8'h00);
      ticks(64);
      pr[r] = bits_reg;
    end
    chk("prbs", 16'($countones(pr[0] ^ pr[1])), 16'h0001);
    // Every error type with both excess-zero definitions
    for (int k = 0; k < 8; k++) begin
      c = 8'((k >> 1) << CTL_TYPE | (k & 1) << CTL_EXZ);
      wr(OFS_CTL, c);
      wr(OFS_CTL, c | 8'h01);
      wr(OFS_CTL, c);
      for (int j = 0; j < 4; j++) repeat (j + 1) ev(4'b1000 >> j);
      x = (k & 1) ? 3 : 2;
      e = k < 2 ? 1 : k < 4 ? x : k < 6 ? 4 : 4 + x;
      wr(OFS_CTL, c | 8'h01);
      cnt_chk(16'(e));
      ev(4'b1111);
      wr(OFS_CTL, c | 8'h01);
      cnt_chk(16'(e));
    end
    // Automatic report, then manual mode leaves the result alone
    wr(OFS_CTL, 8'h02);
    err_req <= ilc_rx_err_s'(4'b1000);
    repeat (150) @(posedge clk);
    cnt_chk(16'(SEC));
    wr(OFS_CTL, 8'h00);
    err_req <= '0;
    repeat (150) @(posedge clk);
    cnt_chk(16'(SEC));
    end_of_test();
  end
endmodule : ilc_top_tb
